// >>> rtl/period_timer.sv
// prescaled 16-bit down-counting period timer with an AXI4-Lite register slave
// assumes one clock, synchronous active-low reset, and a master on the same clock
module period_timer (
   input  wire logic                 clk_i,
   input  wire logic                 nrst_i,
   input  wire logic                 ce_i,
   input  wire timer_pkg::axil_req_t axi_i,
   output timer_pkg::axil_rsp_t      axi_o,
   output logic                      irq_o
);
   import timer_pkg::*;

   timer_state_t       s_q;
   timer_state_t       s_d;
   logic               aw_hs;
   logic               w_hs;
   logic               ar_hs;
   logic [DATA_W-1:0]  wr_val;
   logic [DATA_W-1:0]  ctrl_view;
   logic               cnt_load;
   logic [CNT_W-1:0]   cnt_load_val;
   logic               psc_load;
   logic [RATIO_W-1:0] psc_load_val;
   logic               wr_go;
   logic [RATIO_W-1:0] psc_val;
   logic               psc_borrow;
   logic [CNT_W-1:0]   cnt_val;
   logic               cnt_borrow;
   logic [ADDR_W-1:0]  wr_addr;
   logic [ADDR_W-1:0]  rd_addr;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                               input logic [DATA_W-1:0] new_v,
                                               input logic [3:0]        strb);
      logic [DATA_W-1:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // counting chain
   // ----------------------------------------------------------------
   // prescaler only runs while started; its underflow is the counter tick
   down_counter #(
      .W       (RATIO_W),
      .RST_VAL (PSC_RST)
   ) u_prescaler (
      .clk_i        (clk_i),
      .nrst_i       (nrst_i),
      .ce_i         (ce_i),
      .load_i       (psc_load),
      .load_val_i   (psc_load_val),
      .dec_i        (!s_q.stop),
      .reload_val_i (s_q.ratio),
      .value_o      (psc_val),
      .borrow_o     (psc_borrow)
   );

   down_counter #(
      .W       (CNT_W),
      .RST_VAL (COUNT_RST)
   ) u_counter (
      .clk_i        (clk_i),
      .nrst_i       (nrst_i),
      .ce_i         (ce_i),
      .load_i       (cnt_load),
      .load_val_i   (cnt_load_val),
      .dec_i        (psc_borrow),
      .reload_val_i (s_q.period),
      .value_o      (cnt_val),
      .borrow_o     (cnt_borrow)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d          = s_q;
      wr_val       = '0;
      cnt_load     = 1'b0;
      cnt_load_val = s_q.period;
      psc_load     = 1'b0;
      psc_load_val = s_q.ratio;
      aw_hs        = axi_i.awvalid && s_q.rsp.awready;
      w_hs         = axi_i.wvalid && s_q.rsp.wready;
      ar_hs        = axi_i.arvalid && s_q.rsp.arready;
      ctrl_view    = '0;
      ctrl_view[RATIO_LSB +: RATIO_W] = s_q.ratio;
      ctrl_view[STOP_BIT]             = s_q.stop;
      ctrl_view[PSC_LSB +: RATIO_W]   = psc_val;

      // address and data are taken in either order
      if (aw_hs) begin
         s_d.aw_have = 1'b1;
         s_d.awaddr  = axi_i.awaddr;
      end
      if (w_hs) begin
         s_d.w_have = 1'b1;
         s_d.wdata  = axi_i.wdata;
         s_d.wstrb  = axi_i.wstrb;
      end
      wr_addr = {s_d.awaddr[ADDR_W-1:2], 2'b00};
      rd_addr = {axi_i.araddr[ADDR_W-1:2], 2'b00};

      if (s_q.rsp.bvalid && axi_i.bready) begin
         s_d.rsp.bvalid = 1'b0;
      end
      // a pending response blocks the next write, one write in flight
      wr_go = s_d.aw_have && s_d.w_have && !s_q.rsp.bvalid;
      if (wr_go) begin
         s_d.aw_have    = 1'b0;
         s_d.w_have     = 1'b0;
         s_d.rsp.bvalid = 1'b1;
         s_d.rsp.bresp  = RESP_OKAY;
         case (wr_addr)
            OFS_CTRL: begin
               wr_val    = merge(ctrl_view, s_d.wdata, s_d.wstrb);
               s_d.ratio = wr_val[RATIO_LSB +: RATIO_W];
               s_d.stop  = wr_val[STOP_BIT];
               if (s_d.wstrb[0] && s_d.wdata[RELOAD_BIT]) begin
                  cnt_load = 1'b1;
                  psc_load = 1'b1;
                  // reload takes the ratio written alongside it
                  psc_load_val = s_d.ratio;
               end
            end
            OFS_PERIOD: begin
               wr_val     = merge({16'h0000, s_q.period}, s_d.wdata, s_d.wstrb);
               s_d.period = wr_val[CNT_W-1:0];
            end
            OFS_COUNT: begin
               wr_val       = merge({16'h0000, cnt_val}, s_d.wdata, s_d.wstrb);
               cnt_load     = 1'b1;
               cnt_load_val = wr_val[CNT_W-1:0];
            end
            OFS_STAT: begin
               if (s_d.wstrb[0] && s_d.wdata[EVT_BIT]) begin
                  s_d.evt_stat = 1'b0;
               end
            end
            OFS_MASK: begin
               if (s_d.wstrb[0]) begin
                  s_d.evt_mask = s_d.wdata[EVT_BIT];
               end
            end
            default: begin
               s_d.rsp.bresp = RESP_SLVERR;
            end
         endcase
      end

      // borrow after the clear so a same-cycle event is kept
      if (cnt_borrow && !cnt_load) begin
         s_d.evt_stat = 1'b1;
      end

      if (s_q.rsp.rvalid && axi_i.rready) begin
         s_d.rsp.rvalid = 1'b0;
      end
      if (ar_hs) begin
         s_d.rsp.rvalid = 1'b1;
         s_d.rsp.rresp  = RESP_OKAY;
         s_d.rsp.rdata  = '0;
         case (rd_addr)
            OFS_CTRL:   s_d.rsp.rdata = ctrl_view;
            OFS_PERIOD: s_d.rsp.rdata[CNT_W-1:0] = s_q.period;
            OFS_COUNT:  s_d.rsp.rdata[CNT_W-1:0] = cnt_val;
            OFS_STAT:   s_d.rsp.rdata[EVT_BIT] = s_q.evt_stat;
            OFS_MASK:   s_d.rsp.rdata[EVT_BIT] = s_q.evt_mask;
            default:    s_d.rsp.rresp = RESP_SLVERR;
         endcase
      end

      // ready flags are registered so every output leaves a flop
      s_d.rsp.awready = !s_d.aw_have;
      s_d.rsp.wready  = !s_d.w_have;
      s_d.rsp.arready = !s_d.rsp.rvalid;
      s_d.irq         = s_d.evt_stat && s_d.evt_mask;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s_q <= STATE_RST;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign axi_o = s_q.rsp;
   assign irq_o = s_q.irq;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   borrow_reload_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && cnt_borrow && !cnt_load) |=> (cnt_val == $past(s_q.period)))
      else $error("counter did not take period on borrow");

   reload_bit_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && cnt_load && psc_load) |=> (cnt_val == $past(s_q.period)) && (psc_val == $past(s_d.ratio)))
      else $error("reload request did not copy period");

   period_reset_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(nrst_i) |-> (s_q.period == 16'hffff))
      else $error("period not all ones after reset");

   count_read_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && ar_hs && rd_addr == OFS_COUNT) |=> axi_o.rvalid && (axi_o.rdata == {16'h0000, $past(cnt_val)}))
      else $error("count read not live value");

   count_reset_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(nrst_i) |-> (cnt_val == 16'hffff) && (psc_val == 4'h0))
      else $error("count not all ones after reset");

   stop_freeze_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && s_q.stop && !cnt_load && !psc_load) |=> $stable(cnt_val) && $stable(psc_val))
      else $error("timer moved while stopped");

   psc_read_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && ar_hs && rd_addr == OFS_CTRL) |=> (axi_o.rdata[PSC_LSB +: RATIO_W] == $past(psc_val)))
      else $error("prescaler count not visible");

   run_reset_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(nrst_i) |-> (s_q.ratio == 4'h0) && !s_q.stop)
      else $error("timer not running with zero ratio after reset");

   tick_dec_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && psc_borrow && cnt_val != 16'h0000 && !cnt_load)
      |=> (cnt_val == $past(cnt_val) - 16'h0001) && (psc_val == $past(s_q.ratio)))
      else $error("prescaler underflow did not step counter");

   irq_level_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && cnt_borrow && !cnt_load && s_d.evt_mask) |=> irq_o)
      else $error("unmasked borrow did not raise interrupt");

   bresp_hold_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (axi_o.bvalid && !axi_i.bready) |=> axi_o.bvalid && $stable(axi_o.bresp))
      else $error("write response dropped before accepted");

   rdata_hold_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (axi_o.rvalid && !axi_i.rready) |=> axi_o.rvalid && $stable(axi_o.rdata) && $stable(axi_o.rresp))
      else $error("read response dropped before accepted");

   ar_block_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      axi_o.rvalid |-> !axi_o.arready)
      else $error("read address accepted while answer pending");

   write_answer_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && wr_go) |=> axi_o.bvalid)
      else $error("write performed without response");

   read_answer_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && ar_hs) |=> axi_o.rvalid)
      else $error("read taken without response");

   read_slverr_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && ar_hs && rd_addr > OFS_MASK) |=> (axi_o.rresp == RESP_SLVERR) && (axi_o.rdata == 32'h0000_0000))
      else $error("unmapped read not refused");

   write_slverr_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && wr_go && wr_addr > OFS_MASK) |=> (axi_o.bresp == RESP_SLVERR))
      else $error("unmapped write not refused");

   freeze_all_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      !ce_i |=> $stable(axi_o) && $stable(irq_o) && $stable(cnt_val) && $stable(psc_val))
      else $error("state moved with clock enable low");

   period_write_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && wr_go && wr_addr == OFS_PERIOD && s_d.wstrb == 4'hf) |=> (s_q.period == $past(s_d.wdata[CNT_W-1:0])))
      else $error("period write did not land");

   count_write_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && wr_go && wr_addr == OFS_COUNT && s_d.wstrb == 4'hf) |=> (cnt_val == $past(s_d.wdata[CNT_W-1:0])))
      else $error("count write did not land");

   stat_clear_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && wr_go && wr_addr == OFS_STAT && s_d.wstrb[0] && s_d.wdata[EVT_BIT] && !cnt_borrow) |=> !s_q.evt_stat)
      else $error("status not cleared by write of one");

   set_wins_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && cnt_borrow && !cnt_load) |=> s_q.evt_stat)
      else $error("borrow event lost");

   mask_write_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && wr_go && wr_addr == OFS_MASK && s_d.wstrb[0]) |=> (s_q.evt_mask == $past(s_d.wdata[EVT_BIT])))
      else $error("mask write did not land");

   ctrl_write_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && wr_go && wr_addr == OFS_CTRL && s_d.wstrb[0])
      |=> (s_q.ratio == $past(s_d.wdata[RATIO_LSB +: RATIO_W])) && (s_q.stop == $past(s_d.wdata[STOP_BIT])))
      else $error("control write did not land");

   psc_step_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && !s_q.stop && psc_val != 4'h0 && !psc_load) |=> (psc_val == $past(psc_val) - 4'h1))
      else $error("prescaler did not step down");

   count_hold_a : assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && !psc_borrow && !cnt_load) |=> $stable(cnt_val))
      else $error("counter moved without a tick");

endmodule

// >>> include/timer_pkg.sv
// package for the prescaled period timer: register map, field layout, reset values, bus carriers
// assumes an AXI4-Lite master with 32-bit data on the same clock as the timer
package timer_pkg;

   // ----------------------------------------------------------------
   // bus shape
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } axil_req_t;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } axil_rsp_t;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STAT   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h10;

   // ----------------------------------------------------------------
   // control register fields, counter width and event bit
   // ----------------------------------------------------------------
   localparam int RATIO_W    = 4;
   localparam int RATIO_LSB  = 0;
   localparam int STOP_BIT   = 4;
   localparam int RELOAD_BIT = 5;
   localparam int PSC_LSB    = 6;
   localparam int CNT_W      = 16;
   localparam int EVT_BIT    = 0;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [RATIO_W-1:0] RATIO_RST  = 4'h0;
   localparam logic               STOP_RST   = 1'b0;
   localparam logic [CNT_W-1:0]   PERIOD_RST = 16'hffff;
   localparam logic [CNT_W-1:0]   COUNT_RST  = 16'hffff;
   localparam logic [RATIO_W-1:0] PSC_RST    = 4'h0;

   // ----------------------------------------------------------------
   // state of the timer top, apart from the prescaler and counter values held in down_counter
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              aw_have;
      logic [ADDR_W-1:0] awaddr;
      logic              w_have;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      axil_rsp_t         rsp;
      logic [RATIO_W-1:0] ratio;
      logic              stop;
      logic [CNT_W-1:0]  period;
      logic              evt_stat;
      logic              evt_mask;
      logic              irq;
   } timer_state_t;

   localparam timer_state_t STATE_RST = '{
      aw_have  : 1'b0,
      awaddr   : 8'h00,
      w_have   : 1'b0,
      wdata    : 32'h0000_0000,
      wstrb    : 4'h0,
      rsp      : '{awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: 2'h0,
                   arready: 1'b1, rvalid: 1'b0, rdata: 32'h0000_0000, rresp: 2'h0},
      ratio    : RATIO_RST,
      stop     : STOP_RST,
      period   : PERIOD_RST,
      evt_stat : 1'b0,
      evt_mask : 1'b0,
      irq      : 1'b0
   };

endpackage

// >>> rtl/down_counter.sv
// loadable down counter that reloads itself on borrow
// assumes load and decrement requests come from logic on the same clock
module down_counter #(
   parameter int         W       = 16,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   input  wire logic         ce_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] load_val_i,
   input  wire logic         dec_i,
   input  wire logic [W-1:0] reload_val_i,
   output logic [W-1:0]      value_o,
   output logic              borrow_o
);

   typedef struct packed {
      logic [W-1:0] value;
   } cnt_state_t;

   cnt_state_t s_q;
   cnt_state_t s_d;

   // ----------------------------------------------------------------
   // next value
   // ----------------------------------------------------------------
   // load wins over counting so software always sees its own write
   always_comb begin
      s_d = s_q;
      if (load_i) begin
         s_d.value = load_val_i;
      end else if (dec_i) begin
         if (s_q.value == '0) begin
            s_d.value = reload_val_i;
         end else begin
            s_d.value = s_q.value - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s_q.value <= RST_VAL;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign value_o  = s_q.value;
   assign borrow_o = dec_i && (s_q.value == '0);

endmodule

// >>> tb/tb_period_timer.sv
// self-checking bench for the prescaled period timer, register bus and interrupt
// assumes timer_pkg compiled first and period_timer as the unit under test
module tb_period_timer;
   timeunit 1ns;
   timeprecision 1ps;
   import timer_pkg::*;

   // ----------------------------------------------------------------
   // signals and notes
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] d;
      logic [31:0] m;
      logic [1:0]  r;
   } exp_t;

   logic        clk_i;
   logic        nrst_i;
   logic        ce_i;
   axil_req_t   req;
   axil_rsp_t   rsp;
   logic        irq_o;
   int          n_fail;
   int          check_count;
   int          seed;
   int          cyc = 0;
   int          t0;
   int          t1;
   logic [31:0] v;
   exp_t        e;
   exp_t        rq[$];
   logic [1:0]  bq[$];

   period_timer uut (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .ce_i   (ce_i),
      .axi_i  (req),
      .axi_o  (rsp),
      .irq_o  (irq_o)
   );

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
   end

   // ----------------------------------------------------------------
   // compare and report
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic fail_out();
      n_fail++;
      conclude();
   endtask

   // oldest note is taken whenever an answer is accepted
   always @(posedge clk_i) begin
      if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
         e = rq.pop_front();
         check(rsp.rdata & e.m, e.d & e.m);
         check({30'h0, rsp.rresp}, {30'h0, e.r});
      end
      if (rsp.bvalid === 1'b1 && req.bready === 1'b1) begin
         check({30'h0, rsp.bresp}, {30'h0, bq.pop_front()});
      end
   end

   // ----------------------------------------------------------------
   // bus master tasks
   // ----------------------------------------------------------------
   // the leading edge keeps a new request off the edge where the last one dropped
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
      int i;
      bq.push_back(r);
      @(posedge clk_i);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= s;
      req.bready  <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge clk_i);
         if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
         if (rsp.bvalid === 1'b1) begin
            req.bready <= 1'b0;
            break;
         end
      end
      if (i == 100) fail_out();
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
      int i;
      rq.push_back('{d: d, m: m, r: r});
      @(posedge clk_i);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge clk_i);
         if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
         if (rsp.rvalid === 1'b1) begin
            req.rready <= 1'b0;
            break;
         end
      end
      if (i == 100) fail_out();
   endtask

   task automatic wait_lvl(input logic lv, output int t);
      int i;
      for (i = 0; i < 200; i++) begin
         @(posedge clk_i);
         if (irq_o === lv) break;
      end
      t = cyc;
      if (i == 200) fail_out();
   endtask

   task automatic do_reset();
      nrst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      nrst_i <= 1'b1;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 32'h9d2f55f5;
      n_fail = 0;
      check_count = 0;
      nrst_i = 1'b0;
      ce_i = 1'b1;
      req = '0;
      do_reset();
      rd(OFS_CTRL, 32'h0, 32'hffff_ffff, RESP_OKAY);
      rd(OFS_PERIOD, 32'hffff, 32'hffff_ffff, RESP_OKAY);
      // counter already running, so only the high bits are fixed
      rd(OFS_COUNT, 32'hffc0, 32'hffff_ffc0, RESP_OKAY);
      wr(OFS_CTRL, 32'h10, 4'hf, RESP_OKAY);
      rd(OFS_CTRL, 32'h10, 32'hffff_ffff, RESP_OKAY);
      wr(OFS_COUNT, 32'h3, 4'hf, RESP_OKAY);
      rd(OFS_COUNT, 32'h3, 32'hffff_ffff, RESP_OKAY);
      wr(OFS_PERIOD, 32'h5, 4'hf, RESP_OKAY);
      wr(OFS_CTRL, 32'h32, 4'hf, RESP_OKAY);
      rd(OFS_COUNT, 32'h5, 32'hffff_ffff, RESP_OKAY);
      rd(OFS_CTRL, 32'h92, 32'hffff_ffff, RESP_OKAY);
      wr(OFS_PERIOD, 32'h0000_aa77, 4'h1, RESP_OKAY);
      rd(OFS_PERIOD, 32'h77, 32'hffff_ffff, RESP_OKAY);
      for (int k = 0; k < 3; k++) begin
         v = $random(seed);
         wr(OFS_PERIOD, v, 4'hf, RESP_OKAY);
         rd(OFS_PERIOD, {16'h0, v[15:0]}, 32'hffff_ffff, RESP_OKAY);
      end
      wr(8'h14, 32'h1234_5678, 4'hf, RESP_SLVERR);
      rd(8'h14, 32'h0, 32'hffff_ffff, RESP_SLVERR);
      // borrow event with the interrupt masked, then unmasked and cleared
      wr(OFS_PERIOD, 32'h7, 4'hf, RESP_OKAY);
      wr(OFS_CTRL, 32'h32, 4'hf, RESP_OKAY);
      wr(OFS_STAT, 32'h1, 4'hf, RESP_OKAY);
      wr(OFS_CTRL, 32'h2, 4'hf, RESP_OKAY);
      repeat (40) @(posedge clk_i);
      wr(OFS_CTRL, 32'h12, 4'hf, RESP_OKAY);
      rd(OFS_STAT, 32'h1, 32'hffff_ffff, RESP_OKAY);
      check({31'h0, irq_o}, 32'h0);
      wr(OFS_MASK, 32'h1, 4'hf, RESP_OKAY);
      rd(OFS_MASK, 32'h1, 32'hffff_ffff, RESP_OKAY);
      check({31'h0, irq_o}, 32'h1);
      wr(OFS_STAT, 32'h1, 4'hf, RESP_OKAY);
      rd(OFS_STAT, 32'h0, 32'hffff_ffff, RESP_OKAY);
      check({31'h0, irq_o}, 32'h0);
      // period 7, ratio 2: one event every 8 * 3 cycles
      wr(OFS_CTRL, 32'h2, 4'hf, RESP_OKAY);
      wait_lvl(1'b1, t0);
      wr(OFS_STAT, 32'h1, 4'hf, RESP_OKAY);
      wait_lvl(1'b0, t1);
      wait_lvl(1'b1, t1);
      check(32'(t1 - t0), 32'd24);
      // frozen clock enable stretches the next interval by the frozen cycles
      wr(OFS_STAT, 32'h1, 4'hf, RESP_OKAY);
      ce_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      ce_i <= 1'b1;
      wait_lvl(1'b1, t0);
      check(32'(t0 - t1), 32'd34);
      // second reset in mid-run
      do_reset();
      rd(OFS_PERIOD, 32'hffff, 32'hffff_ffff, RESP_OKAY);
      rd(OFS_MASK, 32'h0, 32'hffff_ffff, RESP_OKAY);
      rd(OFS_CTRL, 32'h0, 32'hffff_ffff, RESP_OKAY);
      check({31'h0, irq_o}, 32'h0);
      conclude();
   end
endmodule
